// >>> logic/gpio_port_b.sv
// Port B: eight-pin bidirectional port with pull-ups and change interrupt.
// Assumes pins synchronous to clock; Avalon-MM master keeps its request
// steady until it samples waitrequest low.
//
// Overview of operation
// (R1) Eight pins, each independently input or output
// (R2) Direction bit 0 drives latch, 1 inputs
// (R3) Clearing active-low bit enables all pull-ups
// (R4) Output pins never get a pull-up
// (R5) Reset leaves every pull-up disabled
// (R6) Only input pins 7..4 detect change
// (R7) Input compared with snapshot from last read
// (R8) ORed mismatches set change flag bit 0
// (R9) Change interrupt requests wake from low power
// (R10) Port access refreshes snapshot, moves excepted
// (R11) Mismatch keeps setting flag; access before clear
// (R12) Software should avoid polling during change use
// (R13) Input pins 0..3 feed external interrupts
// (R14) Pin 3 carries channel 2 when selected
// (R15) Programming mode gives pins 6,7 away
// (R16) Port read gives pins; write loads latch
// (R17) Change interrupt gated by enable, priority bit
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "gpio_port_b_regs.svh"

module gpio_port_b
    import gpio_port_b_pkg::*;
#(
    parameter int PORT_WIDTH = 8    // Pin count of the port
) (
    input  wire logic        clock,              // System clock, 50 MHz
    input  wire logic        rst_b,              // Power-on reset, active low
    input  wire logic [4:0]  address,            // Avalon byte address
    input  wire logic        read,               // Avalon read
    input  wire logic        write,              // Avalon write
    input  wire logic [31:0] writedata,          // Avalon write data
    input  wire logic [3:0]  byteenable,         // Avalon byte lanes
    output logic      [31:0] readdata,           // Avalon read data
    output logic             waitrequest,        // Avalon stall
    input  wire logic        reg_to_reg_move,    // Access is a register move
    input  wire logic [7:0]  pin_in,             // Pin levels
    output logic      [7:0]  pin_out,            // Pin drive values
    output logic      [7:0]  pin_oe,             // Pin drive enables
    output logic      [7:0]  pullup_on,          // Weak pull-up enables
    output logic      [3:0]  ext_irq_in,         // Levels to external irq logic
    input  wire logic        ch2_pin_select,     // 0 puts channel 2 on pin 3
    input  wire logic        ch2_compare_out,    // Channel 2 compare/PWM level
    output logic             ch2_capture_in,     // Pin 3 level for capture
    input  wire logic        prog_enable,        // Programming/debug active
    input  wire logic        prog_data_out,      // Programming data drive value
    input  wire logic        prog_data_oe,       // Programming data drive enable
    output logic             prog_clock_in,      // Programming clock from pin 6
    output logic             prog_data_in,       // Programming data from pin 7
    output logic             change_irq,         // Enabled change interrupt
    output logic             change_irq_high,    // Change interrupt is high priority
    output logic             wake_request,       // Wake from low-power modes
    output logic             irq                 // Unmasked status interrupt
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (PORT_WIDTH != 8) begin : g_width_check
        $error("gpio_port_b serves exactly eight pins");
    end

    port_state_type state;
    port_state_type next_state;

    // ------------------------------------------------------------------------
    // Per-pin change detect and external interrupt edges
    // ------------------------------------------------------------------------
    logic [3:0] mismatch;
    logic [3:0] ext_level;
    logic [3:0] ext_rise;

    for (genvar i = 0; i < 4; i++) begin : g_pin
        localparam int P = i + `BIT_CHANGE_PIN_LOW;
        logic excluded;
        assign excluded = (state.direction_b[P] == 1'b0)                          // R6
                        || (prog_enable && (P >= `BIT_PROG_CLOCK_PIN));           // R15
        assign mismatch[i] = !excluded && (pin_in[P] != state.snapshot[i]);      // R7
        assign ext_level[i] = state.direction_b[i] && pin_in[i];                 // R13
        assign ext_rise[i]  = ext_level[i] && !state.ext_prev[i];
    end

    logic any_mismatch;
    assign any_mismatch = |mismatch;                                             // R8

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic        request;
    logic        accept_wr;
    logic        accept_rd;
    logic        lane0;
    logic        port_touch;
    logic [31:0] read_mux;

    assign request    = read || write;
    assign accept_wr  = write && !state.waitrequest;
    assign accept_rd  = read && !state.waitrequest;
    assign lane0      = byteenable[0];
    assign port_touch = (accept_wr || accept_rd) && (address == `OFS_PIN_LEVEL_B)
                      && !reg_to_reg_move;                                       // R10

    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (address)
            `OFS_PIN_LEVEL_B:          read_mux[7:0] = pin_in;                   // R16
            `OFS_OUTPUT_LATCH_B:       read_mux[7:0] = state.output_latch_b;
            `OFS_DIRECTION_B:          read_mux[7:0] = state.direction_b;
            `OFS_INT_CONTROL_MAIN:     read_mux[7:0] = state.int_main;
            `OFS_INT_CONTROL_EDGE:     read_mux[7:0] = state.int_edge;
            `OFS_INT_CONTROL_EXTERNAL: read_mux[7:0] = state.int_external;
            `OFS_IRQ_STATUS:           read_mux[4:0] = state.irq_status;
            `OFS_IRQ_MASK:             read_mux[4:0] = state.irq_mask;
            default:                   read_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [7:0] wbyte;
        logic       wr_en;
        logic [4:0] status_clear;
        logic [4:0] events;
        logic       pullups_global;
        wbyte          = writedata[7:0];
        wr_en          = accept_wr && lane0;
        status_clear   = 5'h00;
        events         = 5'h00;
        pullups_global = 1'b0;
        next_state     = state;

        // One-wait-state handshake: answer the cycle after a request appears
        next_state.waitrequest = !(request && state.waitrequest);
        if (request && state.waitrequest) begin
            next_state.readdata = read ? read_mux : 32'h0000_0000;
        end

        // Register writes
        if (wr_en) begin
            unique case (address)
                `OFS_PIN_LEVEL_B:          next_state.output_latch_b = wbyte;     // R16
                `OFS_OUTPUT_LATCH_B:       next_state.output_latch_b = wbyte;
                `OFS_DIRECTION_B:          next_state.direction_b = wbyte;        // R1
                `OFS_INT_CONTROL_MAIN:     next_state.int_main = wbyte;
                `OFS_INT_CONTROL_EDGE:     next_state.int_edge = wbyte;           // R3
                `OFS_INT_CONTROL_EXTERNAL: next_state.int_external = wbyte;
                `OFS_IRQ_STATUS:           status_clear = wbyte[4:0];
                `OFS_IRQ_MASK:             next_state.irq_mask = wbyte[4:0];
                default:                   next_state.irq_mask = state.irq_mask;
            endcase
        end

        // Snapshot refresh: a read keeps the value it returned
        if (port_touch) begin                                                     // R10
            next_state.snapshot = accept_rd ? state.readdata[7:4] : pin_in[7:4];
        end

        // A live mismatch sets the flag over any clear in the same cycle
        if (any_mismatch) begin                                                   // R11
            next_state.int_main[`BIT_CHANGE_IRQ_FLAG] = 1'b1;                     // R8
        end

        // Sticky status, set wins over write-one-to-clear
        events[`BIT_STATUS_CHANGE] = any_mismatch;
        events[4:1] = ext_rise;
        next_state.irq_status = (state.irq_status & ~status_clear) | events;
        next_state.ext_prev   = ext_level;
        next_state.irq        = |(next_state.irq_status & next_state.irq_mask);

        // Change interrupt towards the processor and the wake logic
        next_state.change_irq = next_state.int_main[`BIT_CHANGE_IRQ_FLAG]
                              && next_state.int_main[`BIT_CHANGE_IRQ_ENABLE];     // R17
        next_state.change_irq_high = next_state.change_irq
                              && next_state.int_edge[`BIT_CHANGE_IRQ_PRIORITY];   // R17
        next_state.wake_request = next_state.change_irq;                          // R9

        // Pin drivers and pull-ups
        pullups_global = !next_state.int_edge[`BIT_PULLUP_ENABLE_N];              // R3
        for (int p = 0; p < 8; p++) begin
            next_state.pin_oe[p]    = !next_state.direction_b[p];                 // R2
            next_state.pin_out[p]   = next_state.output_latch_b[p];               // R2
            next_state.pullup_on[p] = pullups_global && next_state.direction_b[p]; // R4
        end
        if (!ch2_pin_select && !next_state.direction_b[`BIT_CH2_PIN]) begin
            next_state.pin_out[`BIT_CH2_PIN] = ch2_compare_out;                   // R14
        end
        if (prog_enable) begin                                                    // R15
            next_state.pin_oe[`BIT_PROG_CLOCK_PIN]    = 1'b0;
            next_state.pin_out[`BIT_PROG_CLOCK_PIN]   = 1'b0;
            next_state.pullup_on[`BIT_PROG_CLOCK_PIN] = 1'b0;
            next_state.pin_oe[`BIT_PROG_DATA_PIN]     = prog_data_oe;
            next_state.pin_out[`BIT_PROG_DATA_PIN]    = prog_data_out;
            next_state.pullup_on[`BIT_PROG_DATA_PIN]  = 1'b0;
        end

        // Inputs towards other blocks
        // Same direction as pin_oe, so no level leaks from a pin turning output
        next_state.ext_irq_in     = next_state.direction_b[3:0] & pin_in[3:0];    // R13
        next_state.ch2_capture_in = !ch2_pin_select
                                  && next_state.direction_b[`BIT_CH2_PIN]
                                  && pin_in[`BIT_CH2_PIN];                        // R14
        next_state.prog_clock_in  = prog_enable && pin_in[`BIT_PROG_CLOCK_PIN];   // R15
        next_state.prog_data_in   = prog_enable && pin_in[`BIT_PROG_DATA_PIN];    // R15
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state                <= '0;
            state.waitrequest    <= 1'b1;
            state.output_latch_b <= `RST_OUTPUT_LATCH_B;
            state.direction_b    <= `RST_DIRECTION_B;
            state.int_main       <= `RST_INT_CONTROL_MAIN;
            state.int_edge       <= `RST_INT_CONTROL_EDGE;                        // R5
            state.int_external   <= `RST_INT_CONTROL_EXTERNAL;
            state.irq_status     <= `RST_IRQ_STATUS;
            state.irq_mask       <= `RST_IRQ_MASK;
            // Edge history starts high: a pin idling high is no rise
            state.ext_prev       <= `RST_EXT_LEVEL_PREV;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign readdata        = state.readdata;
    assign waitrequest     = state.waitrequest;
    assign pin_out         = state.pin_out;
    assign pin_oe          = state.pin_oe;
    assign pullup_on       = state.pullup_on;
    assign ext_irq_in      = state.ext_irq_in;
    assign ch2_capture_in  = state.ch2_capture_in;
    assign prog_clock_in   = state.prog_clock_in;
    assign prog_data_in    = state.prog_data_in;
    assign change_irq      = state.change_irq;
    assign change_irq_high = state.change_irq_high;
    assign wake_request    = state.wake_request;
    assign irq             = state.irq;

endmodule // gpio_port_b

// >>> logic/gpio_port_b_pkg.sv
// Types of the port B block: the packed state record of the port module.
// Assumes the register header sits beside it in logic/.
`include "gpio_port_b_regs.svh"

package gpio_port_b_pkg;

    // ------------------------------------------------------------------------
    // Whole state of the port module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
        logic [7:0]  output_latch_b;
        logic [7:0]  direction_b;
        logic [7:0]  int_main;
        logic [7:0]  int_edge;
        logic [7:0]  int_external;
        logic [3:0]  snapshot;
        logic [4:0]  irq_status;
        logic [4:0]  irq_mask;
        logic [3:0]  ext_prev;
        logic        irq;
        logic        change_irq;
        logic        change_irq_high;
        logic        wake_request;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic [7:0]  pullup_on;
        logic [3:0]  ext_irq_in;
        logic        ch2_capture_in;
        logic        prog_clock_in;
        logic        prog_data_in;
    } port_state_type;

endpackage

// >>> logic/gpio_port_b_regs.svh
// Register offsets, bit positions and reset values of port B.
// Assumes inclusion by the package and the port module; definitions only.
`ifndef GPIO_PORT_B_REGS_SVH
`define GPIO_PORT_B_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------------
`define OFS_PIN_LEVEL_B          5'h00
`define OFS_OUTPUT_LATCH_B       5'h04
`define OFS_DIRECTION_B          5'h08
`define OFS_INT_CONTROL_MAIN     5'h0c
`define OFS_INT_CONTROL_EDGE     5'h10
`define OFS_INT_CONTROL_EXTERNAL 5'h14
`define OFS_IRQ_STATUS           5'h18
`define OFS_IRQ_MASK             5'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_CHANGE_IRQ_FLAG      0
`define BIT_CHANGE_IRQ_ENABLE    3
`define BIT_PULLUP_ENABLE_N      7
`define BIT_CHANGE_IRQ_PRIORITY  0
`define BIT_STATUS_CHANGE        0
`define BIT_STATUS_EXT_LOW       1
`define BIT_CHANGE_PIN_LOW       4
`define BIT_CH2_PIN              3
`define BIT_PROG_CLOCK_PIN       6
`define BIT_PROG_DATA_PIN        7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_OUTPUT_LATCH_B       8'h00
`define RST_DIRECTION_B          8'hff
`define RST_INT_CONTROL_MAIN     8'h00
`define RST_INT_CONTROL_EDGE     8'h80
`define RST_INT_CONTROL_EXTERNAL 8'h00
`define RST_IRQ_STATUS           5'h00
`define RST_IRQ_MASK             5'h00
`define RST_EXT_LEVEL_PREV       4'hf

`endif

// >>> tb/gpio_port_b_monitor.sv
// Concurrent checks on the port B pins, bus handshake and interrupt outputs.
// Assumes binding into gpio_port_b; sees only its ports.
`timescale 1ns/1ps
module gpio_port_b_monitor
    import gpio_port_b_pkg::*;
(
    input wire logic       clock,           // System clock
    input wire logic       rst_b,           // Reset, active low
    input wire logic       read,            // Avalon read
    input wire logic       write,           // Avalon write
    input wire logic       waitrequest,     // Avalon stall
    input wire logic [7:0] pin_oe,          // Pin drive enables
    input wire logic [7:0] pullup_on,       // Pull-up enables
    input wire logic [3:0] ext_irq_in,      // External irq levels
    input wire logic       ch2_capture_in,  // Capture level
    input wire logic       prog_enable,     // Programming active
    input wire logic       prog_clock_in,   // Programming clock
    input wire logic       change_irq,      // Change interrupt
    input wire logic       change_irq_high, // High priority
    input wire logic       wake_request     // Wake request
);
    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_request;
        (read || write) && waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_request |=> s_answer)
        else $error("bus answer not one wait then one ready cycle");
    AST_PULLUP_OUTPUT: assert property ((pullup_on & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_EXT_INPUT_ONLY: assert property ((ext_irq_in & pin_oe[3:0]) == 4'h0)
        else $error("external irq fed from an output pin");
    AST_CAPTURE_INPUT: assert property (ch2_capture_in |-> !pin_oe[3])
        else $error("capture level while pin 3 drives");
    AST_PROG_CLOCK_IDLE: assert property (!$past(prog_enable) |-> !prog_clock_in)
        else $error("programming clock outside programming mode");
    AST_PROG_NO_DRIVE: assert property (prog_enable |=> !pin_oe[6])
        else $error("pin 6 driven in programming mode");
    AST_WAKE_CHANGE: assert property ($rose(change_irq) |-> ##[0:1] wake_request)
        else $error("no wake request for change interrupt");
    AST_HIGH_ENABLED: assert property (change_irq_high |-> change_irq)
        else $error("high priority without change interrupt");
endmodule // gpio_port_b_monitor

bind gpio_port_b gpio_port_b_monitor u_monitor (
    .clock(clock), .rst_b(rst_b), .read(read), .write(write),
    .waitrequest(waitrequest), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_irq_in(ext_irq_in), .ch2_capture_in(ch2_capture_in),
    .prog_enable(prog_enable), .prog_clock_in(prog_clock_in), .change_irq(change_irq),
    .change_irq_high(change_irq_high), .wake_request(wake_request)
);

// >>> tb/gpio_port_b_pins.sv
// Board-side model of the eight port B pins.
// Assumes the bench sets the external drive; undriven pins float.
`timescale 1ns/1ps
module gpio_port_b_pins (
    input wire logic       clock,     // System clock
    input wire logic [7:0] pin_out,   // Port drive values
    input wire logic [7:0] pin_oe,    // Port drive enables
    input wire logic [7:0] pullup_on, // Weak pull-ups
    input wire logic [7:0] ext_val,   // Board drive values
    input wire logic [7:0] ext_en,    // Board drive enables
    output logic     [7:0] pin_in     // Resolved pin levels
);
    // ------------------------------------------------------------------------
    // Resolution: port, then board, then pull-up, else a wandering level
    // ------------------------------------------------------------------------
    logic [7:0] last;
    always_ff @(posedge clock) begin
        last <= pin_in;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pullup_on[i]) pin_in[i] = 1'b1;
            else pin_in[i] = ~last[i];
        end
    end
endmodule // gpio_port_b_pins

// >>> tb/test_gpio_port_b.sv
// Self-checking bench of port B: registers, pins, change detect, interrupts.
// Assumes the pin model and the bound monitor are compiled with it.
`timescale 1ns/1ps
`include "gpio_port_b_regs.svh"
module test_gpio_port_b
    import gpio_port_b_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals and helpers
    // ------------------------------------------------------------------------
    localparam logic [4:0] A_PIN = `OFS_PIN_LEVEL_B, A_LAT = `OFS_OUTPUT_LATCH_B,
        A_DIR = `OFS_DIRECTION_B, A_MAIN = `OFS_INT_CONTROL_MAIN,
        A_EDGE = `OFS_INT_CONTROL_EDGE, A_STAT = `OFS_IRQ_STATUS, A_MASK = `OFS_IRQ_MASK;
    logic        clock = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, reg_to_reg_move = 1'b0;
    logic        ch2_pin_select = 1'b1, ch2_compare_out = 1'b0, prog_enable = 1'b0;
    logic        prog_data_out = 1'b0, prog_data_oe = 1'b0;
    logic        waitrequest, ch2_capture_in, prog_clock_in, prog_data_in;
    logic        change_irq, change_irq_high, wake_request, irq;
    logic [4:0]  address = 5'h00;
    logic [3:0]  byteenable = 4'hf, be_word = 4'hf, ext_irq_in;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0]  ext_val = 8'h00, ext_en = 8'hff, pin_in, pin_out, pin_oe, pullup_on;
    int          errors = 0, total_checks = 0;
    always #10 clock = ~clock;
    gpio_port_b u_dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .reg_to_reg_move(reg_to_reg_move), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_irq_in(ext_irq_in),
        .ch2_pin_select(ch2_pin_select), .ch2_compare_out(ch2_compare_out),
        .ch2_capture_in(ch2_capture_in), .prog_enable(prog_enable),
        .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
        .prog_clock_in(prog_clock_in), .prog_data_in(prog_data_in), .change_irq(change_irq),
        .change_irq_high(change_irq_high), .wake_request(wake_request), .irq(irq));
    gpio_port_b_pins u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
                          output logic [31:0] q);
        int n;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be_word;
        read <= rd;
        write <= !rd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        if (waitrequest !== 1'b0) begin
            errors++;
            tally_and_finish();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        access(1'b0, a, d, q);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b1, a, 8'h00, q);
        check(q, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        check(32'(pullup_on), 32'h0);
        rdchk(A_DIR, 32'hff);
        rdchk(A_EDGE, 32'h80);
        rdchk(A_LAT, 32'h00);
        rdchk(A_MAIN, 32'h00);
        rdchk(A_MASK, 32'h00);
        rdchk(`OFS_INT_CONTROL_EXTERNAL, 32'h00);
        wr(`OFS_INT_CONTROL_EXTERNAL, 8'h3c);
        rdchk(`OFS_INT_CONTROL_EXTERNAL, 32'h3c);
        wr(5'h02, 8'h77);
        rdchk(5'h02, 32'h00);
        $display("t_reset done");
    endtask
    task automatic t_drive();
        wr(A_DIR, 8'hcf);
        wr(A_LAT, 8'ha5);
        settle();
        check(32'(pin_oe), 32'h30);
        check(32'(pin_in[5:4]), 32'h2);
        wr(A_PIN, 8'h5a);
        rdchk(A_LAT, 32'h5a);
        be_word = 4'h0;
        wr(A_LAT, 8'h11);
        be_word = 4'hf;
        rdchk(A_LAT, 32'h5a);
        rdchk(A_PIN, 32'h10);
        ext_en <= 8'h00;
        wr(A_EDGE, 8'h00);
        settle();
        check(32'(pullup_on), 32'hcf);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        check(32'(pullup_on), 32'h0);
        check(32'(pin_oe), 32'h0);
        rst_b <= 1'b1;
        rdchk(A_EDGE, 32'h80);
        wr(A_EDGE, 8'h80);
        settle();
        check(32'(pullup_on), 32'h00);
        ext_en <= 8'hff;
        $display("t_drive done");
    endtask
    task automatic t_change();
        wr(A_DIR, 8'hff);
        settle();
        rdchk(A_PIN, 32'h00);
        wr(A_MAIN, 8'h08);
        ext_val <= 8'h04;
        settle();
        rdchk(A_MAIN, 32'h08);
        wr(A_DIR, 8'hef);
        settle();
        rdchk(A_MAIN, 32'h08);
        wr(A_DIR, 8'hff);
        ext_val <= 8'h24;
        settle();
        rdchk(A_MAIN, 32'h09);
        check(32'({change_irq, wake_request, change_irq_high}), 32'h6);
        wr(A_EDGE, 8'h81);
        settle();
        check(32'(change_irq_high), 32'h1);
        wr(A_EDGE, 8'h80);
        wr(A_MAIN, 8'h08);
        settle();
        rdchk(A_MAIN, 32'h09);
        reg_to_reg_move <= 1'b1;
        rdchk(A_PIN, 32'h24);
        reg_to_reg_move <= 1'b0;
        wr(A_MAIN, 8'h08);
        settle();
        rdchk(A_MAIN, 32'h09);
        rdchk(A_PIN, 32'h24);
        wr(A_MAIN, 8'h08);
        settle();
        rdchk(A_MAIN, 32'h08);
        ext_val <= 8'h04;
        wr(A_MAIN, 8'h00);
        settle();
        rdchk(A_MAIN, 32'h01);
        check(32'(change_irq), 32'h0);
        rdchk(A_PIN, 32'h04);
        wr(A_STAT, 8'h1f);
        settle();
        rdchk(A_STAT, 32'h00);
        ext_val <= 8'h05;
        settle();
        rdchk(A_STAT, 32'h02);
        check(32'(irq), 32'h0);
        wr(A_MASK, 8'h02);
        settle();
        check(32'(irq), 32'h1);
        wr(A_STAT, 8'h02);
        settle();
        check(32'(irq), 32'h0);
        $display("t_change done");
    endtask
    task automatic t_alt();
        ext_val <= 8'h0a;
        settle();
        check(32'(ext_irq_in), 32'ha);
        wr(A_DIR, 8'hf7);
        wr(A_LAT, 8'h52);
        ch2_pin_select <= 1'b0;
        ch2_compare_out <= 1'b1;
        settle();
        check(32'({ext_irq_in, pin_out[3]}), 32'h5);
        ch2_pin_select <= 1'b1;
        settle();
        check(32'(pin_out[3]), 32'h0);
        ch2_pin_select <= 1'b0;
        wr(A_DIR, 8'h3f);
        settle();
        check(32'(ch2_capture_in), 32'h1);
        ext_val <= 8'h4a;
        prog_enable <= 1'b1;
        prog_data_oe <= 1'b1;
        prog_data_out <= 1'b1;
        settle();
        check(32'({pin_oe[7:6], pin_out[7], prog_clock_in}), 32'hb);
        prog_data_oe <= 1'b0;
        settle();
        check(32'({pin_oe[7], prog_data_in}), 32'h0);
        prog_enable <= 1'b0;
        settle();
        check(32'({pin_oe[7:6], prog_clock_in}), 32'h6);
        $display("t_alt done");
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_drive();
        t_change();
        t_alt();
        tally_and_finish();
    end
endmodule // test_gpio_port_b
